/* File: curmon.sv */
// Purpose: output current level monitor with high and zero current flags
// Assumes: current_pct sampled on clock; run and tuning are sync levels
// Notes:   one relay terminal and one open collector terminal
//
// Function
// - High flag asserts after current stays above level longer than period.
// - High level accepts 0 to 200.0 percent, defaults 150 percent.
// - High period accepts 0 to 10 s, defaults 0.
// - High flag holds at least about 100 ms once asserted, unless run and tuning both drop.
// - Both detectors keep working during offline auto tuning.
// - Zero flag asserts after current stays below level longer than period.
// - Zero level accepts 0 to 200.0 percent, defaults 5.0 percent.
// - Zero period accepts 0.05 to 1 s, defaults 0.5 s.
// - Short dip below zero level still pulses the zero flag 100 ms, unless run and tuning both drop.
// - Flags are routed to terminals by the function select setting.
`timescale 1ns/100ps
module curmon
  import curmon_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [11:0] current_pct,
  input  wire logic        drive_running,
  input  wire logic        auto_tuning,
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             high_current_flag,
  output logic             zero_current_flag,
  output logic [1:0]       terminal_out,
  output logic             irq
);
  import curmon_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [11:0] high_current_level;
  logic [13:0] high_current_period;
  logic [11:0] zero_current_level;
  logic [13:0] zero_current_period;
  logic [3:0]  relay_terminal_function_select;
  logic [1:0]  status_r;
  logic [1:0]  irq_en_r;
  logic        ack_r;
  logic [11:0] cur_r;
  logic        active;
  logic        run_r;
  logic        tune_r;

  function automatic logic [11:0] clip_level(input logic [31:0] d);
    clip_level = (d[31:12] != 20'h0 || d[11:0] > LEVEL_MAX) ?
                 LEVEL_MAX : d[11:0];
  endfunction

  function automatic logic [13:0] clip_per(input logic [31:0] d,
                                           input logic [13:0] lo,
                                           input logic [13:0] hi);
    if (d[31:14] != 18'h0 || d[13:0] > hi)
      clip_per = hi;
    else if (d[13:0] < lo)
      clip_per = lo;
    else
      clip_per = d[13:0];
  endfunction

  // One wait state; waitrequest is the flop so the bus sees no glitch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);
  end
  assign ack_r = !waitrequest;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      high_current_level             <= HI_LEVEL_RST;
      high_current_period            <= HI_PERIOD_RST;
      zero_current_level             <= ZERO_LEVEL_RST;
      zero_current_period            <= ZERO_PERIOD_RST;
      relay_terminal_function_select <= {SEL_ZERO, SEL_HIGH};
      irq_en_r                       <= 2'h0;
    end else if (write && ack_r) begin
      unique case (address)
        A_HI_LEVEL:   high_current_level  <= clip_level(writedata);
        A_HI_PERIOD:  high_current_period <=
                        clip_per(writedata, 14'h0, HI_PERIOD_MAX);
        A_ZERO_LEVEL: zero_current_level  <= clip_level(writedata);
        A_ZERO_PER:   zero_current_period <=
                        clip_per(writedata, ZERO_PERIOD_MIN, ZERO_PERIOD_MAX);
        A_TERM_SEL:   relay_terminal_function_select <= writedata[3:0];
        A_IRQ_EN:     irq_en_r <= writedata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      readdata <= 32'h0;
    else if (read && !ack_r) begin
      unique case (address)
        A_HI_LEVEL:   readdata <= {20'h0, high_current_level};
        A_HI_PERIOD:  readdata <= {18'h0, high_current_period};
        A_ZERO_LEVEL: readdata <= {20'h0, zero_current_level};
        A_ZERO_PER:   readdata <= {18'h0, zero_current_period};
        A_TERM_SEL:   readdata <= {28'h0, relay_terminal_function_select};
        A_STATUS:     readdata <= {28'h0, zero_current_flag,
                                   high_current_flag, status_r};
        A_IRQ_EN:     readdata <= {30'h0, irq_en_r};
        default:      readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  // free running tick
  logic [15:0] tick_cnt;
  logic        tick;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= 16'h0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 16'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0 :
                  tick_cnt + 16'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur_r  <= 12'h0;
      run_r  <= 1'b0;
      tune_r <= 1'b0;
    end else begin
      cur_r  <= current_pct;
      run_r  <= drive_running;
      tune_r <= auto_tuning;
    end
  end

  // tuning counts as active; run state sampled with the current
  assign active = run_r || tune_r;

  // ----------------------------------------------------------------
  // High current detector
  // ----------------------------------------------------------------
  logic        hi_cond;
  logic [13:0] hi_tmr;
  logic [6:0]  hi_hold;
  assign hi_cond = active && (cur_r >= high_current_level);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      hi_tmr <= 14'h0;
    else if (!hi_cond)
      hi_tmr <= 14'h0;
    else if (tick && hi_tmr < high_current_period)
      hi_tmr <= hi_tmr + 14'h1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      high_current_flag <= 1'b0;
      hi_hold           <= 7'h0;
    end else if (!active) begin
      high_current_flag <= 1'b0;
      hi_hold           <= 7'h0;
    end else if (hi_cond && hi_tmr >= high_current_period) begin
      high_current_flag <= 1'b1;
      hi_hold           <= HOLD_CNT;
    end else if (hi_hold != 7'h0) begin
      if (tick)
        hi_hold <= hi_hold - 7'h1;
    end else
      high_current_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Zero current detector
  // ----------------------------------------------------------------
  logic        z_cond;
  logic        z_cond_d;
  logic [13:0] z_tmr;
  logic [6:0]  z_hold;
  assign z_cond = active && (cur_r <= zero_current_level);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      z_tmr <= 14'h0;
    else if (!z_cond)
      z_tmr <= 14'h0;
    else if (tick && z_tmr < zero_current_period)
      z_tmr <= z_tmr + 14'h1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      z_cond_d <= 1'b0;
    else
      z_cond_d <= z_cond;
  end

  // a dip that ends early still gives a 100 ms pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      zero_current_flag <= 1'b0;
      z_hold            <= 7'h0;
    end else if (!active) begin
      zero_current_flag <= 1'b0;
      z_hold            <= 7'h0;
    end else if (z_cond && z_tmr >= zero_current_period) begin
      zero_current_flag <= 1'b1;
      z_hold            <= HOLD_CNT;
    end else if (z_cond_d && !z_cond && !zero_current_flag) begin
      zero_current_flag <= 1'b1;
      z_hold            <= HOLD_CNT;
    end else if (z_hold != 7'h0) begin
      if (tick)
        z_hold <= z_hold - 7'h1;
    end else
      zero_current_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Terminal routing and interrupts
  // ----------------------------------------------------------------
  function automatic logic route(input logic [1:0] sel,
                                 input logic h, input logic z);
    unique case (sel)
      SEL_NONE: route = 1'b0;
      SEL_HIGH: route = h;
      SEL_ZERO: route = z;
      SEL_BOTH: route = h | z;
    endcase
  endfunction

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      terminal_out <= 2'h0;
    else
      for (int i = 0; i < NUM_TERM; i++)
        terminal_out[i] <= route(relay_terminal_function_select[2*i +: 2],
                                 high_current_flag, zero_current_flag);
  end

  logic [1:0] rise;
  logic       hf_d;
  logic       zf_d;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hf_d <= 1'b0;
      zf_d <= 1'b0;
    end else begin
      hf_d <= high_current_flag;
      zf_d <= zero_current_flag;
    end
  end
  assign rise = {zero_current_flag & !zf_d, high_current_flag & !hf_d};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      status_r <= 2'h0;
    else if (write && ack_r && address == A_IRQ_CLR)
      status_r <= (status_r & ~writedata[1:0]) | rise;
    else
      status_r <= status_r | rise;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(status_r & irq_en_r);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  stopped_no_flags_a:
    assert property (!active |=> !high_current_flag && !zero_current_flag)
    else $error("flag high while drive stopped");
  hi_assert_qual_a:
    assert property ($rose(high_current_flag) |->
                     $past(hi_cond) && $past(hi_tmr) >= high_current_period)
    else $error("high flag without qualification");
  hi_hold_min_a:
    assert property ($rose(high_current_flag) ##0 active [*8]
                     |-> high_current_flag)
    else $error("high flag dropped too soon");
  hi_level_range_a:
    assert property (high_current_level <= LEVEL_MAX)
    else $error("high level out of range");
  hi_period_range_a:
    assert property (high_current_period <= HI_PERIOD_MAX)
    else $error("high period out of range");
  zero_range_a:
    assert property (zero_current_level <= LEVEL_MAX)
    else $error("zero level out of range");
  zero_period_range_a:
    assert property (zero_current_period >= ZERO_PERIOD_MIN &&
                     zero_current_period <= ZERO_PERIOD_MAX)
    else $error("zero period out of range");
  zero_dip_pulse_a:
    assert property (active && z_cond ##1 active && !z_cond &&
                     !zero_current_flag |=> zero_current_flag)
    else $error("short dip gave no pulse");
  zero_tmr_reset_a:
    assert property (!z_cond |=> z_tmr == 14'h0)
    else $error("zero timer not restarted");
  tuning_active_a:
    assert property (tune_r && cur_r >= high_current_level
                     |-> hi_cond)
    else $error("detector idle in tuning");
  route_a:
    assert property (relay_terminal_function_select[1:0] == SEL_HIGH &&
                     $stable(relay_terminal_function_select)
                     |=> terminal_out[0] == $past(high_current_flag))
    else $error("terminal routing wrong");
endmodule // curmon

/* File: curmon_pkg.sv */
// Purpose: constants for the output current level monitor
// Assumes: 50 MHz clock, current in units of 0.1 percent of rating
// Notes:   register map is word addressed over Avalon-MM
package curmon_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned HOLD_MS         = 100;
  // Current scale: 0.1 percent per count, 2000 = 200.0 percent
  localparam logic [11:0] LEVEL_MAX       = 12'h7d0;
  localparam logic [11:0] HI_LEVEL_RST    = 12'h5dc;
  localparam logic [11:0] ZERO_LEVEL_RST  = 12'h032;
  // Periods in milliseconds
  localparam logic [13:0] HI_PERIOD_MAX   = 14'h2710;
  localparam logic [13:0] HI_PERIOD_RST   = 14'h0000;
  localparam logic [13:0] ZERO_PERIOD_MIN = 14'h0032;
  localparam logic [13:0] ZERO_PERIOD_MAX = 14'h03e8;
  localparam logic [13:0] ZERO_PERIOD_RST = 14'h01f4;
  localparam logic [6:0]  HOLD_CNT        = 7'(HOLD_MS);
  // Word addresses
  localparam logic [2:0] A_HI_LEVEL   = 3'h0;
  localparam logic [2:0] A_HI_PERIOD  = 3'h1;
  localparam logic [2:0] A_ZERO_LEVEL = 3'h2;
  localparam logic [2:0] A_ZERO_PER   = 3'h3;
  localparam logic [2:0] A_TERM_SEL   = 3'h4;
  localparam logic [2:0] A_STATUS    = 3'h5;
  localparam logic [2:0] A_IRQ_EN    = 3'h6;
  localparam logic [2:0] A_IRQ_CLR   = 3'h7;
  // Terminal function select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_ZERO = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  localparam int unsigned NUM_TERM = 2;
  // Status bits
  localparam int unsigned ST_HI   = 0;
  localparam int unsigned ST_ZERO = 1;
endpackage

/* File: curmon_sense_model.sv */
// Purpose: far-side model of the drive's current sensing and run state
// Assumes: one clock; sensed current follows the target one cycle late
// Notes:   a stopped drive carries no current, as a real one would
`timescale 1ns/100ps
module curmon_sense_model (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [11:0] target_pct,
  input  wire logic        run_cmd,
  input  wire logic        tune_cmd,
  output logic      [11:0] current_pct,
  output logic             drive_running,
  output logic             auto_tuning
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      current_pct   <= 12'h000;
      drive_running <= 1'b0;
      auto_tuning   <= 1'b0;
    end else begin
      drive_running <= run_cmd;
      auto_tuning   <= tune_cmd;
      // No output stage active, no current
      current_pct   <= (run_cmd | tune_cmd) ? target_pct : 12'h000;
    end
  end
endmodule // curmon_sense_model

/* File: tb_output_current_level_monitor.sv */
// Purpose: self-checking bench for the current level monitor
// Assumes: 50 MHz clock, 1 ms tick of 50000 cycles from the package
// Notes:   the 100 ms hold is only sampled briefly, to keep the run short
`timescale 1ns/100ps
module tb_output_current_level_monitor;
  import curmon_pkg::*;
  logic        clock, arst_n, run_cmd, tune_cmd, drive_running, auto_tuning;
  logic        read, write, waitrequest, irq;
  logic        high_current_flag, zero_current_flag;
  logic [1:0]  terminal_out;
  logic [2:0]  address;
  logic [11:0] target_pct, current_pct;
  logic [31:0] writedata, readdata;
  logic [31:0] exp_q[$];
  int          error_cnt, checked, seed;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  curmon_sense_model model_u (.clock(clock), .arst_n(arst_n),
    .target_pct(target_pct), .run_cmd(run_cmd), .tune_cmd(tune_cmd),
    .current_pct(current_pct), .drive_running(drive_running),
    .auto_tuning(auto_tuning));

  curmon dut_u (.clock(clock), .arst_n(arst_n), .current_pct(current_pct),
    .drive_running(drive_running), .auto_tuning(auto_tuning),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .high_current_flag(high_current_flag),
    .zero_current_flag(zero_current_flag), .terminal_out(terminal_out),
    .irq(irq));

  // ----------------------------------------
  // Bus, checks and waits
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_rd, input logic [2:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    read      <= is_rd;
    write     <= !is_rd;
    address   <= a;
    writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask

  // Read data taken at the same edge that sees waitrequest low
  always @(posedge clock) begin
    if (read && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) error_cnt++;
      else check(readdata, exp_q.pop_front());
    end
  end

  function automatic logic sig(input int sel);
    case (sel)
      0: return high_current_flag;
      1: return zero_current_flag;
      2: return irq;
      3: return terminal_out[0];
      default: return terminal_out[1];
    endcase
  endfunction

  task automatic wait_sig(input int sel, input logic v, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(negedge clock);
      if (sig(sel) === v) break;
    end
    check(32'(sig(sel)), 32'(v));
  endtask

  task automatic hold_sig(input int sel, input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge clock);
      bad += int'(sig(sel) !== v);
    end
    check(32'(bad), 32'h0);
  endtask

  task automatic set(input logic r, input logic t, input logic [11:0] c);
    @(posedge clock);
    run_cmd    <= r;
    tune_cmd   <= t;
    target_pct <= c;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 22007;
    arst_n = 1'b0;
    run_cmd = 1'b0;
    tune_cmd = 1'b0;
    target_pct = 12'h000;
    read = 1'b0;
    write = 1'b0;
    address = 3'h0;
    writedata = 32'h0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    rd(A_HI_LEVEL, 32'(HI_LEVEL_RST));
    rd(A_HI_PERIOD, 32'(HI_PERIOD_RST));
    rd(A_ZERO_LEVEL, 32'(ZERO_LEVEL_RST));
    rd(A_ZERO_PER, 32'(ZERO_PERIOD_RST));
    rd(A_TERM_SEL, 32'({SEL_ZERO, SEL_HIGH}));
    rd(A_STATUS, 32'h0);
    // Out of range values clamp rather than wrap
    wr(A_HI_LEVEL, 32'hfff);
    rd(A_HI_LEVEL, 32'(LEVEL_MAX));
    wr(A_HI_PERIOD, 32'hffff);
    rd(A_HI_PERIOD, 32'(HI_PERIOD_MAX));
    wr(A_ZERO_PER, 32'h0);
    rd(A_ZERO_PER, 32'(ZERO_PERIOD_MIN));
    wr(A_ZERO_PER, 32'hffff);
    rd(A_ZERO_PER, 32'(ZERO_PERIOD_MAX));
    wr(A_ZERO_LEVEL, 32'hfff);
    rd(A_ZERO_LEVEL, 32'(LEVEL_MAX));
    wr(A_HI_LEVEL, 32'(HI_LEVEL_RST));
    wr(A_HI_PERIOD, 32'h0);
    wr(A_ZERO_LEVEL, 32'(ZERO_LEVEL_RST));
    // Stopped drive: zero current yet no flag
    hold_sig(1, 1'b0, 40);
    wr(A_IRQ_EN, 32'h3);
    set(1'b1, 1'b0, 12'h3e8);
    hold_sig(0, 1'b0, 20);
    set(1'b1, 1'b0, 12'h5dd + 12'($unsigned($random(seed)) % 400));
    wait_sig(0, 1'b1, 8);
    wait_sig(2, 1'b1, 4);
    rd(A_STATUS, 32'h5);
    for (int c = 0; c < 4; c++) begin
      wr(A_TERM_SEL, 32'(c) | 32'h8);
      wait_sig(3, c[0], 4);
    end
    set(1'b1, 1'b0, 12'h3e8);
    hold_sig(0, 1'b1, 60);
    set(1'b0, 1'b0, 12'h3e8);
    wait_sig(0, 1'b0, 4);
    wr(A_IRQ_CLR, 32'h3);
    wait_sig(2, 1'b0, 4);
    rd(A_STATUS, 32'h0);
    // Tuning alone keeps detection live; irq masked off
    wr(A_IRQ_EN, 32'h0);
    set(1'b0, 1'b1, 12'h708);
    wait_sig(0, 1'b1, 8);
    hold_sig(2, 1'b0, 10);
    set(1'b0, 1'b0, 12'h000);
    wait_sig(0, 1'b0, 4);
    // Short dip under the zero level still pulses the flag
    wr(A_ZERO_LEVEL, 32'h1f4);
    wr(A_IRQ_EN, 32'h2);
    set(1'b1, 1'b0, 12'h3e8);
    hold_sig(2, 1'b0, 10);
    set(1'b1, 1'b0, 12'h12c);
    hold_sig(1, 1'b0, 20);
    set(1'b1, 1'b0, 12'h3e8);
    wait_sig(1, 1'b1, 8);
    wait_sig(4, 1'b1, 4);
    wait_sig(2, 1'b1, 4);
    set(1'b0, 1'b0, 12'h000);
    wait_sig(1, 1'b0, 4);
    // Two tick period: tick phase is free, so a one tick window of doubt
    wr(A_HI_PERIOD, 32'h2);
    set(1'b1, 1'b0, 12'h708);
    hold_sig(0, 1'b0, 49000);
    wait_sig(0, 1'b1, 52000);
    give_verdict();
  end

  initial begin
    repeat (110000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
endmodule // tb_output_current_level_monitor
